/* hw/swrc_sleep_wake_reset_control.sv */
`timescale 1ns/1ps
module swrc_sleep_wake_reset_control
  import swrc_pkg::*;
#(
  parameter int LONG_CYC = swrc_pkg::STARTUP_LONG_CYC,
  parameter int SHORT_CYC = swrc_pkg::STARTUP_SHORT_CYC,
  parameter int FILT_CYC = swrc_pkg::FILTER_CYC
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [swrc_pkg::CFG_W-1:0] configWord,
  input wire logic sleepReq,
  input wire logic [3:0] highVoltagePortLow,
  input wire logic highVoltagePort7,
  input wire logic masterClearPinN,
  input wire logic brownoutDet,
  input wire logic watchdogWake,
  output logic coreReset,
  output logic sleeping,
  output logic watchdogEnable,
  output logic fuseSenseEnable,
  output logic lowCoreVoltage,
  output logic brownoutLevel,
  output logic brownoutMonitorEn,
  output logic irq
);
  import swrc_pkg::*;

  if (FILT_CYC < 1) begin : g_bad_filt
    $error("filter count must be at least 1");
  end

  // ==========================================================
  // input filtering
  logic [WAKE_W:0] pinFlt;
  logic [WAKE_W-1:0] wakeLvl;
  logic mclrAsserted;

  swrc_glitch_filter #(
    .WIDTH(WAKE_W + 1),
    .CYCLES(FILT_CYC),
    .RESET_VAL(PIN_RESET)
  ) u_filter (
    .clk_sys(clk_sys),
    .reset(reset),
    .rawIn({masterClearPinN, highVoltagePort7, highVoltagePortLow}),
    .filtered(pinFlt)
  );

  assign wakeLvl = pinFlt[WAKE_W-1:0];
  assign mclrAsserted = !pinFlt[WAKE_W];

  // ==========================================================
  // registers and sequencing state
  swrc_state_t state;
  logic [4:0] ctrl;
  logic [IRQ_W-1:0] irqStat;
  logic [IRQ_W-1:0] irqMask;
  logic unlockArmed;
  logic pcwFlag;
  logic [WAKE_W-1:0] wakeLatch;
  logic wdLatch;
  logic tmrStart;
  logic tmrBusy;
  logic tmrDone;

  logic brownoutActive;
  logic holdReq;
  logic sleepEntry;
  logic pinWake;
  logic wdWake;
  logic shortMode;
  logic wdLive;

  // detector output is ignored until software arms it
  assign brownoutActive = !ctrl[CTRL_BOR_EN_N] && brownoutDet;
  assign holdReq = mclrAsserted || brownoutActive;
  assign sleepEntry = state == ST_RUN && sleepReq && !holdReq;
  // awake, the pins never reach the compare
  assign pinWake = state == ST_SLEEP && ctrl[CTRL_WAKE_EN]
                   && wakeLvl != wakeLatch && !holdReq;
  assign wdWake = state == ST_SLEEP && watchdogWake && wdLatch && !holdReq;
  assign shortMode = configWord[CFG_OSC_HI] && configWord[CFG_OSC_LO];
  assign wdLive = configWord[CFG_WD_FUSE] || ctrl[CTRL_SOFT_WD];

  swrc_startup_timer #(
    .LONG_CYC(LONG_CYC),
    .SHORT_CYC(SHORT_CYC)
  ) u_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .start(tmrStart),
    .shortMode(shortMode),
    .busy(tmrBusy),
    .done(tmrDone)
  );

  // ==========================================================
  // sequencer: hold wins over every other transition
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ST_STARTUP;
      coreReset <= 1'b1;
      sleeping <= 1'b0;
      tmrStart <= 1'b1;
    end else begin
      tmrStart <= 1'b0;
      if (holdReq) begin
        state <= ST_HOLD;
        coreReset <= 1'b1;
        sleeping <= 1'b0;
      end else begin
        case (state)
          ST_HOLD: begin
            state <= ST_STARTUP;
            tmrStart <= 1'b1;
          end
          ST_STARTUP: begin
            if (tmrDone) begin
              state <= ST_RUN;
              coreReset <= 1'b0;
            end
          end
          ST_RUN: begin
            if (sleepReq) begin
              state <= ST_SLEEP;
              sleeping <= 1'b1;
            end
          end
          ST_SLEEP: begin
            if (pinWake || wdWake) begin
              state <= ST_STARTUP;
              coreReset <= 1'b1;
              sleeping <= 1'b0;
              tmrStart <= 1'b1;
            end
          end
          default: state <= ST_STARTUP;
        endcase
      end
    end
  end

  // ==========================================================
  // sleep-entry latches
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wakeLatch <= '0;
      wdLatch <= 1'b0;
    end else if (sleepEntry) begin
      wakeLatch <= wakeLvl;
      wdLatch <= wdLive;
    end
  end

  // wake cause flag: cleared by a pin wake, set by a hold-type reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pcwFlag <= 1'b1;
    end else if (holdReq) begin
      pcwFlag <= 1'b1;
    end else if (pinWake) begin
      pcwFlag <= 1'b0;
    end
  end

  // ==========================================================
  // pin-facing outputs
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      watchdogEnable <= 1'b0;
      fuseSenseEnable <= 1'b1;
      lowCoreVoltage <= 1'b0;
      brownoutLevel <= 1'b0;
      brownoutMonitorEn <= 1'b0;
    end else begin
      // fuse is not sensed in sleep, the latched copy rules instead
      watchdogEnable <= sleeping ? wdLatch : wdLive;
      fuseSenseEnable <= !sleeping;
      lowCoreVoltage <= sleeping && ctrl[CTRL_LOW_VSLEEP];
      brownoutLevel <= ctrl[CTRL_BOR_LEVEL];
      brownoutMonitorEn <= !ctrl[CTRL_BOR_EN_N];
    end
  end

  // ==========================================================
  // apb slave: one wait state, write lands on the pready edge
  logic apbDone;
  logic apbWr;
  logic [31:0] rdMux;
  logic mapped;
  logic [IRQ_W-1:0] irqEvent;
  logic [7:0] statByte;

  assign apbDone = psel && penable && pready;
  assign apbWr = apbDone && pwrite && !pslverr;
  assign statByte = {3'h0, tmrBusy, coreReset, watchdogEnable, sleeping, pcwFlag};

  always_comb begin
    mapped = 1'b1;
    case (paddr)
      OFS_CTRL: rdMux = swrc_zext({3'h0, ctrl});
      OFS_STAT: rdMux = swrc_zext(statByte);
      OFS_IRQ_STAT: rdMux = swrc_zext({4'h0, irqStat});
      OFS_IRQ_MASK: rdMux = swrc_zext({4'h0, irqMask});
      OFS_UNLOCK: rdMux = swrc_zext({7'h00, unlockArmed});
      default: begin
        rdMux = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite) begin
        prdata <= rdMux;
      end
    end
  end

  // control register with interlocked trip level
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrl <= CTRL_RESET;
      unlockArmed <= 1'b0;
    end else if (apbWr && paddr == OFS_UNLOCK) begin
      unlockArmed <= pwdata[7:0] == UNLOCK_KEY;
    end else if (apbWr && paddr == OFS_CTRL) begin
      ctrl[CTRL_WAKE_EN] <= pwdata[CTRL_WAKE_EN];
      ctrl[CTRL_BOR_EN_N] <= pwdata[CTRL_BOR_EN_N];
      ctrl[CTRL_LOW_VSLEEP] <= pwdata[CTRL_LOW_VSLEEP];
      ctrl[CTRL_SOFT_WD] <= pwdata[CTRL_SOFT_WD];
      // level moves only with key armed and the detector off, so a live
      // monitor never sees its threshold jump
      if (unlockArmed && ctrl[CTRL_BOR_EN_N]) begin
        ctrl[CTRL_BOR_LEVEL] <= pwdata[CTRL_BOR_LEVEL];
      end
      unlockArmed <= 1'b0;
    end
  end

  // ==========================================================
  // interrupts: sticky, write one to clear, a new event wins
  always_comb begin
    irqEvent = '0;
    irqEvent[IRQ_PIN_WAKE] = pinWake;
    irqEvent[IRQ_BROWNOUT] = brownoutActive && state != ST_HOLD;
    irqEvent[IRQ_MASTER_CLEAR_PIN] = mclrAsserted && state != ST_HOLD;
    irqEvent[IRQ_WD_WAKE] = wdWake;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irqStat <= IRQ_RESET;
      irqMask <= IRQ_RESET;
      irq <= 1'b0;
    end else begin
      if (apbWr && paddr == OFS_IRQ_STAT) begin
        irqStat <= (irqStat & ~pwdata[IRQ_W-1:0]) | irqEvent;
      end else begin
        irqStat <= irqStat | irqEvent;
      end
      if (apbWr && paddr == OFS_IRQ_MASK) begin
        irqMask <= pwdata[IRQ_W-1:0];
      end
      irq <= |(irqStat & irqMask);
    end
  end

  // ==========================================================
  // checks
  property p_wake_latch;
    @(posedge clk_sys) disable iff (reset)
      sleepEntry |=> wakeLatch == $past(wakeLvl) && state == ST_SLEEP;
  endproperty
  a_wake_latch: assert property (p_wake_latch) else $error("wake levels not latched");

  property p_pin_wake;
    @(posedge clk_sys) disable iff (reset)
      pinWake |=> coreReset && state == ST_STARTUP && tmrStart ##1 tmrBusy;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake missed warm reset");

  property p_flag_clear;
    @(posedge clk_sys) disable iff (reset)
      pinWake |=> !pcwFlag && irqStat[IRQ_PIN_WAKE];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("wake flag not cleared");

  property p_no_false_wake;
    @(posedge clk_sys) disable iff (reset)
      state == ST_SLEEP && wakeLvl == wakeLatch && !watchdogWake && !holdReq
      |=> state == ST_SLEEP && sleeping;
  endproperty
  a_no_false_wake: assert property (p_no_false_wake) else $error("wake without change");

  property p_wake_disabled;
    @(posedge clk_sys) disable iff (reset)
      state == ST_SLEEP && !ctrl[CTRL_WAKE_EN] && !watchdogWake && !holdReq
      |=> state == ST_SLEEP;
  endproperty
  a_wake_disabled: assert property (p_wake_disabled) else $error("wake while disabled");

  property p_port7_wake;
    @(posedge clk_sys) disable iff (reset)
      state == ST_SLEEP && ctrl[CTRL_WAKE_EN] && wakeLvl[WAKE_W-1] != wakeLatch[WAKE_W-1]
      && !holdReq |=> !pcwFlag && coreReset;
  endproperty
  a_port7_wake: assert property (p_port7_wake) else $error("bit 7 wake lost");

  property p_bor_hold;
    @(posedge clk_sys) disable iff (reset)
      brownoutActive ##1 brownoutActive |-> coreReset && state == ST_HOLD && !sleeping;
  endproperty
  a_bor_hold: assert property (p_bor_hold) else $error("core ran in brown-out");

  property p_level_lock;
    @(posedge clk_sys) disable iff (reset)
      !ctrl[CTRL_BOR_EN_N] |=> $stable(ctrl[CTRL_BOR_LEVEL]);
  endproperty
  a_level_lock: assert property (p_level_lock) else $error("level moved while armed");

  property p_wd_sleep;
    @(posedge clk_sys) disable iff (reset)
      sleeping ##1 sleeping |-> watchdogEnable == wdLatch && !fuseSenseEnable;
  endproperty
  a_wd_sleep: assert property (p_wd_sleep) else $error("watchdog not frozen in sleep");

  property p_wd_awake;
    @(posedge clk_sys) disable iff (reset)
      !sleeping ##1 !sleeping |-> watchdogEnable == $past(wdLive);
  endproperty
  a_wd_awake: assert property (p_wd_awake) else $error("watchdog enable wrong");

  property p_lowv;
    @(posedge clk_sys) disable iff (reset)
      lowCoreVoltage |-> $past(sleeping) && $past(ctrl[CTRL_LOW_VSLEEP]);
  endproperty
  a_lowv: assert property (p_lowv) else $error("low voltage outside sleep");

  property p_awake_ignore;
    @(posedge clk_sys) disable iff (reset)
      state == ST_RUN && !sleepReq && !holdReq |=> state == ST_RUN && !coreReset;
  endproperty
  a_awake_ignore: assert property (p_awake_ignore) else $error("pins acted while awake");
endmodule : swrc_sleep_wake_reset_control

/* hw/swrc_pkg.sv */
package swrc_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 100;
  localparam int CLK_NS = 10;
  localparam int STARTUP_LONG_US = 18000;
  localparam int STARTUP_SHORT_US = 1000;
  localparam int STARTUP_LONG_CYC = STARTUP_LONG_US * CLK_MHZ;
  localparam int STARTUP_SHORT_CYC = STARTUP_SHORT_US * CLK_MHZ;
  localparam int FILTER_NS = 200;
  localparam int FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
  // ==========================================================
  // register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_UNLOCK = 8'h10;
  localparam int CTRL_WAKE_EN = 0;
  localparam int CTRL_BOR_EN_N = 1;
  localparam int CTRL_LOW_VSLEEP = 2;
  localparam int CTRL_BOR_LEVEL = 3;
  localparam int CTRL_SOFT_WD = 4;
  localparam logic [4:0] CTRL_RESET = 5'h02;
  localparam logic [7:0] UNLOCK_KEY = 8'h5A;
  localparam int STAT_PCW_FLAG = 0;
  localparam int STAT_SLEEP = 1;
  localparam int STAT_WD_EN = 2;
  localparam int STAT_CORE_RST = 3;
  localparam int STAT_STARTUP = 4;
  localparam int IRQ_PIN_WAKE = 0;
  localparam int IRQ_BROWNOUT = 1;
  localparam int IRQ_MASTER_CLEAR_PIN = 2;
  localparam int IRQ_WD_WAKE = 3;
  localparam int IRQ_W = 4;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;
  // ==========================================================
  // configuration word and pins
  localparam int CFG_W = 12;
  localparam int CFG_OSC_LO = 0;
  localparam int CFG_OSC_HI = 1;
  localparam int CFG_WD_FUSE = 2;
  localparam int WAKE_W = 5;
  localparam logic [WAKE_W:0] PIN_RESET = 6'h20;

  typedef enum logic [1:0] {ST_STARTUP, ST_RUN, ST_SLEEP, ST_HOLD} swrc_state_t;

  function automatic logic [31:0] swrc_zext(input logic [7:0] b);
    return {24'h000000, b};
  endfunction : swrc_zext
endpackage : swrc_pkg

/* hw/swrc_glitch_filter.sv */
`timescale 1ns/1ps
module swrc_glitch_filter #(
  parameter int WIDTH = 6,
  parameter int CYCLES = 20,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] rawIn,
  output logic [WIDTH-1:0] filtered
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  if (CYCLES < 1 || WIDTH < 1) begin : g_bad_cfg
    $error("glitch filter needs CYCLES and WIDTH of at least 1");
  end

  // a level moves only after it differs for CYCLES cycles in a row
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [CW-1:0] cnt;
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        cnt <= '0;
        filtered[i] <= RESET_VAL[i];
      end else if (rawIn[i] == filtered[i]) begin
        cnt <= '0;
      end else if (cnt == LAST) begin
        cnt <= '0;
        filtered[i] <= rawIn[i];
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule : swrc_glitch_filter

/* hw/swrc_startup_timer.sv */
`timescale 1ns/1ps
module swrc_startup_timer #(
  parameter int LONG_CYC = 1800000,
  parameter int SHORT_CYC = 100000
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic start,
  input wire logic shortMode,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(LONG_CYC + 1);
  logic [CW-1:0] cnt;

  if (SHORT_CYC < 1 || SHORT_CYC > LONG_CYC) begin : g_bad_cfg
    $error("start-up counts out of range");
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        cnt <= shortMode ? CW'(SHORT_CYC - 1) : CW'(LONG_CYC - 1);
      end else if (busy) begin
        if (cnt == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - 1'b1;
        end
      end
    end
  end

  property p_short_load;
    @(posedge clk_sys) disable iff (reset)
      start && shortMode |=> busy && cnt == CW'(SHORT_CYC - 1);
  endproperty
  a_short_load: assert property (p_short_load) else $error("short wait not loaded");

  property p_long_load;
    @(posedge clk_sys) disable iff (reset)
      start && !shortMode |=> busy && cnt == CW'(LONG_CYC - 1);
  endproperty
  a_long_load: assert property (p_long_load) else $error("long wait not loaded");
endmodule : swrc_startup_timer

/* tb/swrc_wake_partner.sv */
`timescale 1ns/1ps
module swrc_wake_partner (
  input wire logic clk_sys,
  output logic [3:0] highVoltagePortLow,
  output logic highVoltagePort7,
  output logic masterClearPinN,
  output logic brownoutDet
);
  logic [4:0] pins;
  // ==========================================================
  // pin levels; index 4 stands for port bit 7
  initial begin
    pins = 5'h00;
    masterClearPinN = 1'b1;
    brownoutDet = 1'b0;
  end
  assign highVoltagePortLow = pins[3:0];
  assign highVoltagePort7 = pins[4];

  task automatic set_pin(input int i, input logic v);
    @(posedge clk_sys);
    pins[i] <= v;
  endtask : set_pin

  // a pulse shorter than the filter window must be ignored by the device
  task automatic glitch(input int i, input int len);
    @(posedge clk_sys);
    pins[i] <= ~pins[i];
    repeat (len) @(posedge clk_sys);
    pins[i] <= ~pins[i];
  endtask : glitch

  task automatic set_master_clear_pin(input logic v);
    @(posedge clk_sys);
    masterClearPinN <= v;
  endtask : set_master_clear_pin

  task automatic set_brown(input logic v);
    @(posedge clk_sys);
    brownoutDet <= v;
  endtask : set_brown
endmodule : swrc_wake_partner

/* tb/sleep_wake_reset_control_tb_top.sv */
`timescale 1ns/1ps
module sleep_wake_reset_control_tb_top;
  import swrc_pkg::*;
  // short counts keep the run brief; expectations derive from these
  localparam int LC = 200;
  localparam int SC = 50;
  localparam int FC = 3;
  logic clk_sys, reset, psel, penable, pwrite, sleepReq, watchdogWake, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [CFG_W-1:0] configWord;
  logic [3:0] highVoltagePortLow;
  logic highVoltagePort7, masterClearPinN, brownoutDet, coreReset, sleeping, irq;
  logic watchdogEnable, fuseSenseEnable, lowCoreVoltage, brownoutLevel, brownoutMonitorEn;
  int miscompares, checksDone, cyc, n;

  swrc_sleep_wake_reset_control #(.LONG_CYC(LC), .SHORT_CYC(SC), .FILT_CYC(FC)) DUT (
    .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .configWord(configWord), .sleepReq(sleepReq), .highVoltagePortLow(highVoltagePortLow),
    .highVoltagePort7(highVoltagePort7), .masterClearPinN(masterClearPinN),
    .brownoutDet(brownoutDet), .watchdogWake(watchdogWake), .coreReset(coreReset),
    .sleeping(sleeping), .watchdogEnable(watchdogEnable), .fuseSenseEnable(fuseSenseEnable),
    .lowCoreVoltage(lowCoreVoltage), .brownoutLevel(brownoutLevel),
    .brownoutMonitorEn(brownoutMonitorEn), .irq(irq));

  swrc_wake_partner wp (.clk_sys(clk_sys), .highVoltagePortLow(highVoltagePortLow),
    .highVoltagePort7(highVoltagePort7), .masterClearPinN(masterClearPinN),
    .brownoutDet(brownoutDet));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // checking and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask : chk1

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk1(pready, 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask : rd_chk

  task automatic wait_rst(input logic v, input int lim);
    n = 0;
    while (coreReset !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk1(coreReset, v);
  endtask : wait_rst

  task automatic go_sleep;
    @(posedge clk_sys);
    sleepReq <= 1'b1;
    @(posedge clk_sys);
    sleepReq <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk1(sleeping, 1'b1);
  endtask : go_sleep

  task automatic master_clear_pin_pulse;
    wp.set_master_clear_pin(1'b0);
    wait_rst(1'b1, FC + 8);
    wp.set_master_clear_pin(1'b1);
    repeat (FC + 2) @(posedge clk_sys);
    wait_rst(1'b0, SC + 20);
    chk1(n >= SC - 12, 1'b1);
  endtask : master_clear_pin_pulse

  // ==========================================================
  // scenarios
  task automatic t_power_up;
    chk1(watchdogEnable, 1'b0);
    chk1(brownoutMonitorEn, 1'b0);
    rd_chk(OFS_CTRL, 32'hFF, 32'h02);
    rd_chk(OFS_STAT, 32'h1, 32'h1);
    wait_rst(1'b0, LC + 20);
    chk1(n >= LC - 20, 1'b1);
    apb(1'b0, 8'hF0, 32'h0);
    chk1(err, 1'b1);
    chk(rd, 32'h0);
  endtask : t_power_up

  task automatic irq_check;
    chk1(irq, 1'b0);
    rd_chk(OFS_IRQ_STAT, 32'h1, 32'h1);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk1(irq, 1'b1);
    apb(1'b1, OFS_IRQ_STAT, 32'hF);
    repeat (2) @(posedge clk_sys);
    chk1(irq, 1'b0);
  endtask : irq_check

  task automatic t_pin_wake;
    logic [4:0] lv;
    int p;
    lv = 5'h00;
    configWord <= 12'h003;
    master_clear_pin_pulse();
    // each pin toggles twice, so the second pass wakes on a latched one
    for (int i = 0; i < 10; i++) begin
      p = (i + 4) % 5;
      apb(1'b1, OFS_CTRL, 32'h07);
      go_sleep();
      chk1(lowCoreVoltage, 1'b1);
      if (i == 0) begin
        wp.glitch(p, FC - 1);
        repeat (FC + 4) @(posedge clk_sys);
        chk1(sleeping, 1'b1);
      end
      lv[p] = ~lv[p];
      wp.set_pin(p, lv[p]);
      wait_rst(1'b1, FC + 8);
      rd_chk(OFS_STAT, 32'h3, 32'h0);
      wait_rst(1'b0, SC + 20);
      chk1(n >= SC - 20, 1'b1);
      if (i == 0) irq_check();
      master_clear_pin_pulse();
      rd_chk(OFS_STAT, 32'h1, 32'h1);
    end
    wp.set_pin(2, 1'b1);
    repeat (FC + 8) @(posedge clk_sys);
    chk1(coreReset, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h06);
    go_sleep();
    // watchdog latched off here, so its time-out must not wake either
    watchdogWake <= 1'b1;
    wp.set_pin(2, 1'b0);
    repeat (FC + 8) @(posedge clk_sys);
    watchdogWake <= 1'b0;
    chk1(sleeping, 1'b1);
    master_clear_pin_pulse();
  endtask : t_pin_wake

  task automatic t_watchdog;
    configWord <= 12'h007;
    repeat (3) @(posedge clk_sys);
    chk1(watchdogEnable, 1'b1);
    go_sleep();
    configWord <= 12'h003;
    repeat (4) @(posedge clk_sys);
    chk({30'h0, watchdogEnable, fuseSenseEnable}, 32'h2);
    // a latched-on watchdog wakes the core and leaves the pin-change flag set
    watchdogWake <= 1'b1;
    @(posedge clk_sys);
    watchdogWake <= 1'b0;
    wait_rst(1'b1, 4);
    rd_chk(OFS_STAT, 32'h1, 32'h1);
    wait_rst(1'b0, SC + 20);
    master_clear_pin_pulse();
    chk1(watchdogEnable, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h12);
    repeat (2) @(posedge clk_sys);
    chk1(watchdogEnable, 1'b1);
    apb(1'b1, OFS_CTRL, 32'h02);
    repeat (2) @(posedge clk_sys);
    chk1(watchdogEnable, 1'b0);
  endtask : t_watchdog

  task automatic t_brownout;
    apb(1'b1, OFS_CTRL, 32'h0A);
    repeat (2) @(posedge clk_sys);
    chk1(brownoutLevel, 1'b0);
    apb(1'b1, OFS_UNLOCK, {24'h0, UNLOCK_KEY});
    apb(1'b1, OFS_CTRL, 32'h0A);
    repeat (2) @(posedge clk_sys);
    chk1(brownoutLevel, 1'b1);
    wp.set_brown(1'b1);
    repeat (8) @(posedge clk_sys);
    chk1(coreReset, 1'b0);
    apb(1'b1, OFS_CTRL, 32'h08);
    repeat (3) @(posedge clk_sys);
    chk({30'h0, brownoutMonitorEn, coreReset}, 32'h3);
    repeat (30) @(posedge clk_sys);
    chk1(coreReset, 1'b1);
    wp.set_brown(1'b0);
    wait_rst(1'b0, SC + 20);
    rd_chk(OFS_STAT, 32'h1, 32'h1);
  endtask : t_brownout

  // ==========================================================
  // verdict and hang guard
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      miscompares++;
      report_and_stop();
    end
  end

  initial begin
    cyc = 0;
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    configWord = 12'h000;
    sleepReq = 1'b0;
    watchdogWake = 1'b0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_power_up();
    t_pin_wake();
    t_watchdog();
    t_brownout();
    report_and_stop();
  end
endmodule : sleep_wake_reset_control_tb_top
